// ===== hw/pcrf_pkg.sv
package pcrf_pkg;
   // register offsets are register indices on the bus
   localparam logic [3:0] REG_TRIM0 = 4'h1;
   localparam logic [3:0] REG_TRIM1 = 4'h2;
   localparam logic [3:0] REG_RFLG = 4'h3;
   localparam logic [3:0] REG_SYNR = 4'h4;
   localparam logic [3:0] REG_REF_DIV = 4'h5;
   localparam logic [3:0] REG_OUT_DIV = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;
   // reset-cause flag positions
   localparam int PWRON_BIT = 6;
   localparam int LOWV_BIT = 5;
   localparam int WDRF_BIT = 3;
   localparam int OSCLOSS_BIT = 1;
   localparam int PLLLOSS_BIT = 0;
   localparam logic [7:0] RFLG_MASK = 8'h6B;
   // implemented bits of the trim and divider registers
   localparam logic [7:0] TRIM0_MASK = 8'h0F;
   localparam logic [7:0] TRIM1_MASK = 8'h3F;
   localparam logic [7:0] REF_DIV_MASK = 8'hCF;
   localparam logic [7:0] OUT_DIV_MASK = 8'h1F;
   // reset values and fixed codes
   localparam logic [7:0] SYNR_RST = 8'h00;
   localparam logic [7:0] REF_DIV_RST = 8'h00;
   localparam logic [4:0] OUT_DIV_RST = 5'h00;
   localparam logic [1:0] FILTER_1M = 2'h0;
   localparam logic [4:0] UNLOCK_DIV = 5'h03;
   localparam logic [5:0] RAMP_CYCLES = 6'h20;
   typedef enum logic [2:0] {
      TL_IDLE = 3'b001,
      TL_FETCH = 3'b010,
      TL_DONE = 3'b100
   } pcrf_trim_e;
endpackage

// ===== hw/pcrf_ramp_if.sv
`timescale 1ns/10ps
interface pcrf_ramp_if;
   logic [4:0] target;
   logic [4:0] current;
   logic restart;
   logic settled;
   modport ctrl(output target, output restart, input current, input settled);
   modport ramp(input target, input restart, output current, output settled);
endinterface

// ===== hw/pcrf_div_ramp.sv
`timescale 1ns/10ps
module pcrf_div_ramp
   import pcrf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   pcrf_ramp_if.ramp rp
);
   logic [4:0] cur_r;
   logic [5:0] cnt_r;
   assign rp.current = cur_r;
   assign rp.settled = (cur_r == rp.target);
   // one step per cycle toward target, so at most 31 steps
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cur_r <= UNLOCK_DIV;
      end else if (cur_r < rp.target) begin
         cur_r <= cur_r + 5'h01;
      end else if (cur_r > rp.target) begin
         cur_r <= cur_r - 5'h01;
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= 6'h00;
      end else if (rp.restart) begin
         cnt_r <= 6'h00;
      end else if (!rp.settled && cnt_r != RAMP_CYCLES) begin
         cnt_r <= cnt_r + 6'h01;
      end
   end
   a_ramp_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cnt_r <= RAMP_CYCLES) else $error("ramp took too long"); // [RQ17]
endmodule

// ===== hw/pcrf_top.sv
`timescale 1ns/10ps
// Summary of operation
// RQ1: trim registers writable only in special mode; readable always.
// RQ2: trim registers loaded from flash after system reset release.
// RQ3: power-on reset sets bit 6; system reset keeps it.
// RQ4: low-voltage reset on any domain or power-on sets bit 5.
// RQ5: watchdog, osc-loss, pll-loss set bits 3,1,0; power-on clears.
// RQ6: flags clear only on writing one; zero leaves them.
// RQ7: synthesizer and reference divider writes need protect low, pll selected.
// RQ8: accepted synthesizer write clears lock and oscillator status.
// RQ9: accepted reference divider write clears lock and oscillator status.
// RQ10: locked vco equals two times reference times multiplier plus one.
// RQ11: software picks vco range 00 or 01; 10, 11 reserved.
// RQ12: reference is osc over divider plus one, else internal 1 MHz.
// RQ13: software sets reference range code by reference frequency.
// RQ14: internal reference forces filter 1-2 MHz; field still stores.
// RQ15: post divider writes accepted only while pll selected.
// RQ16: pll out is vco over output divider+1 locked, over 4 unlocked.
// RQ17: output divider ramps to target within 32 cycles.
// RQ18: reserved bits read zero and ignore writes.
module pcrf_top (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic por_rst,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   input wire logic special_mode,
   input wire logic pll_select,
   input wire logic write_protect,
   input wire logic osc_enable,
   input wire logic lock_raw,
   input wire logic osc_ok_raw,
   input wire logic lvr_event,
   input wire logic wdog_event,
   input wire logic osc_loss_event,
   input wire logic pll_loss_event,
   output logic flashReq,
   output logic flashSel,
   input wire logic flashAck,
   input wire logic [7:0] flashData,
   output logic [5:0] multiplier_field,
   output logic [1:0] vco_range_field,
   output logic [3:0] reference_divider_field,
   output logic [1:0] filter_range,
   output logic use_internal_ref,
   output logic [4:0] pllDivider,
   output logic pll_settled,
   output logic osc_qualified,
   output logic statusClear
);
   import pcrf_pkg::*;
   logic [7:0] trim0_r, trim1_r, rflg_r, synr_r, ref_div_r;
   logic [4:0] out_div_r;
   logic [5:0] rampAge_r;
   logic [7:0] rdata_r;
   logic lock_s1_r, lock_s2_r, osc_s1_r, osc_s2_r;
   logic [3:0] ev_s1_r, ev_s2_r;
   logic lock_sync_r, osc_sync_r, lock_prev_r;
   logic rel_s1_r, rel_s2_r;
   logic flashSel_r;
   pcrf_trim_e tl_r;
   logic wrTrim, wrSynth, wrRef, wrPost, anyClr;
   pcrf_ramp_if rif();

   assign wrTrim = regWr && special_mode; // [RQ1]
   assign wrSynth = regWr && regAddr == REG_SYNR
      && !write_protect && pll_select; // [RQ7]
   assign wrRef = regWr && regAddr == REG_REF_DIV
      && !write_protect && pll_select; // [RQ7]
   assign wrPost = regWr && regAddr == REG_OUT_DIV && pll_select; // [RQ15]
   assign anyClr = wrSynth || wrRef; // [RQ8] [RQ9]
   assign statusClear = anyClr;

   // all foreign inputs through two flops
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lock_s1_r <= 1'b0;
         lock_s2_r <= 1'b0;
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         ev_s1_r <= 4'h0;
         ev_s2_r <= 4'h0;
         rel_s1_r <= 1'b0;
         rel_s2_r <= 1'b0;
      end else begin
         lock_s1_r <= lock_raw;
         lock_s2_r <= lock_s1_r;
         osc_s1_r <= osc_ok_raw;
         osc_s2_r <= osc_s1_r;
         ev_s1_r <= {lvr_event, wdog_event, osc_loss_event, pll_loss_event};
         ev_s2_r <= ev_s1_r;
         rel_s1_r <= 1'b1;
         rel_s2_r <= rel_s1_r;
      end
   end

   // status drops for one cycle on reconfiguration, then follows the synchronized raw level again
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lock_sync_r <= 1'b0;
         osc_sync_r <= 1'b0;
         lock_prev_r <= 1'b0;
      end else begin
         lock_sync_r <= anyClr ? 1'b0 : lock_s2_r; // [RQ8] [RQ9]
         osc_sync_r <= anyClr ? 1'b0 : osc_s2_r; // [RQ8] [RQ9]
         lock_prev_r <= lock_sync_r;
      end
   end
   assign pll_settled = lock_sync_r;
   assign osc_qualified = osc_sync_r;

   // reset flags live on the power-on reset only; system reset spares them
   always_ff @(posedge ref_clk or posedge por_rst) begin
      if (por_rst) begin
         rflg_r <= 8'h60; // [RQ3] [RQ4] [RQ5]
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (regWr && regAddr == REG_RFLG && regWdata[i]) begin
               rflg_r[i] <= 1'b0; // [RQ6]
            end
         end
         // set beats a same-cycle clear
         if (ev_s2_r[3]) begin
            rflg_r[LOWV_BIT] <= 1'b1; // [RQ4]
         end
         if (ev_s2_r[2]) begin
            rflg_r[WDRF_BIT] <= 1'b1; // [RQ5]
         end
         if (ev_s2_r[1]) begin
            rflg_r[OSCLOSS_BIT] <= 1'b1; // [RQ5]
         end
         if (ev_s2_r[0]) begin
            rflg_r[PLLLOSS_BIT] <= 1'b1; // [RQ5]
         end
      end
   end

   // trim loader: fetch both words once the reset release is seen
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tl_r <= TL_IDLE;
         flashSel_r <= 1'b0;
      end else begin
         case (tl_r)
            TL_IDLE: begin
               if (rel_s2_r) tl_r <= TL_FETCH; // [RQ2]
            end
            TL_FETCH: begin
               if (flashAck) begin
                  if (flashSel_r) tl_r <= TL_DONE;
                  flashSel_r <= ~flashSel_r;
               end
            end
            TL_DONE: tl_r <= TL_DONE;
            default: tl_r <= TL_IDLE;
         endcase
      end
   end
   assign flashReq = (tl_r == TL_FETCH);
   assign flashSel = flashSel_r;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         trim0_r <= 8'h00;
         trim1_r <= 8'h00;
      end else begin
         if (tl_r == TL_FETCH && flashAck && !flashSel_r) begin
            trim0_r <= flashData & TRIM0_MASK; // [RQ2]
         end else if (wrTrim && regAddr == REG_TRIM0) begin
            trim0_r <= regWdata & TRIM0_MASK; // [RQ1] [RQ18]
         end
         if (tl_r == TL_FETCH && flashAck && flashSel_r) begin
            trim1_r <= flashData & TRIM1_MASK; // [RQ2]
         end else if (wrTrim && regAddr == REG_TRIM1) begin
            trim1_r <= regWdata & TRIM1_MASK; // [RQ1] [RQ18]
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         synr_r <= SYNR_RST;
         ref_div_r <= REF_DIV_RST;
         out_div_r <= OUT_DIV_RST;
      end else begin
         if (wrSynth) begin
            synr_r <= regWdata; // [RQ7]
         end
         if (wrRef) begin
            ref_div_r <= regWdata & REF_DIV_MASK; // [RQ7] [RQ18]
         end
         if (wrPost) begin
            out_div_r <= regWdata[4:0]; // [RQ15]
         end
      end
   end

   // vco = 2*ref*(mult+1) is set by these fields in the analog loop
   assign multiplier_field = synr_r[5:0]; // [RQ10]
   assign vco_range_field = synr_r[7:6];
   assign reference_divider_field = ref_div_r[3:0]; // [RQ12]
   assign use_internal_ref = !osc_enable; // [RQ12]
   assign filter_range = osc_enable ? ref_div_r[7:6] : FILTER_1M; // [RQ14]

   // unlocked runs divide-by-4; lock or a new value restarts the ramp
   assign rif.target = lock_sync_r ? out_div_r : UNLOCK_DIV; // [RQ16]

   // cycles since the last ramp restart; parks at the bound to stay quiet
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rampAge_r <= RAMP_CYCLES;
      end else if (rif.restart) begin
         rampAge_r <= 6'h00;
      end else if (rampAge_r < RAMP_CYCLES) begin
         rampAge_r <= rampAge_r + 6'h01;
      end
   end
   assign rif.restart = wrPost || (lock_sync_r && !lock_prev_r); // [RQ17]
   pcrf_div_ramp u_ramp (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .rp(rif.ramp)
   );
   assign pllDivider = rif.current;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            REG_TRIM0: rdata_r <= trim0_r;
            REG_TRIM1: rdata_r <= trim1_r;
            REG_RFLG: rdata_r <= rflg_r & RFLG_MASK; // [RQ18]
            REG_SYNR: rdata_r <= synr_r;
            REG_REF_DIV: rdata_r <= ref_div_r;
            REG_OUT_DIV: rdata_r <= {3'h0, out_div_r};
            REG_STATUS: rdata_r <= {6'h00, lock_sync_r, osc_sync_r};
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end
   assign regRdata = rdata_r;

   a_trim_normal: assert property (@(posedge ref_clk) disable iff (sys_rst)
      regWr && !special_mode && tl_r == TL_DONE |=> $stable(trim0_r)
      && $stable(trim1_r)) else $error("trim changed in normal mode"); // [RQ1]
   a_synth_guard: assert property (@(posedge ref_clk) disable iff (sys_rst)
      regWr && regAddr == REG_SYNR && (write_protect || !pll_select)
      |=> $stable(synr_r)) else $error("guarded write took"); // [RQ7]
   a_synth_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wrSynth |=> !pll_settled && !osc_qualified)
      else $error("status not cleared"); // [RQ8]
   a_ref_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wrRef |=> !pll_settled && !osc_qualified)
      else $error("status not cleared"); // [RQ9]
   a_post_guard: assert property (@(posedge ref_clk) disable iff (sys_rst)
      regWr && regAddr == REG_OUT_DIV && !pll_select |=> $stable(out_div_r))
      else $error("post divider took write"); // [RQ15]
   a_filter_int: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !osc_enable |-> filter_range == FILTER_1M)
      else $error("filter not fixed"); // [RQ14]
   a_flag_set: assert property (@(posedge ref_clk) disable iff (por_rst)
      ev_s2_r[2] |=> rflg_r[WDRF_BIT]) else $error("flag lost"); // [RQ5]
   a_flag_zero: assert property (@(posedge ref_clk) disable iff (por_rst)
      regWr && regAddr == REG_RFLG && !regWdata[PWRON_BIT]
      && $past(rflg_r[PWRON_BIT]) |=> rflg_r[PWRON_BIT])
      else $error("zero cleared flag"); // [RQ6]
   a_unlock_ramp: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !lock_sync_r ##1 !lock_sync_r [*7] |-> pllDivider == UNLOCK_DIV)
      else $error("unlock divider wrong"); // [RQ16]
   a_ramp_done: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rampAge_r == RAMP_CYCLES - 6'h01 && lock_sync_r |-> rif.settled)
      else $error("ramp not settled"); // [RQ17]
   a_ref_guard: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ7]
      regWr && regAddr == REG_REF_DIV && (write_protect || !pll_select)
      |=> $stable(ref_div_r)) else $error("guarded write took");
   a_post_take: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ15]
      wrPost |=> out_div_r == $past(regWdata[4:0]))
      else $error("output divider write lost");
   a_syn_take: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ7]
      wrSynth |=> synr_r == $past(regWdata))
      else $error("synthesizer write lost");
   a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ18]
      regRd && (regAddr == 4'h0 || regAddr > REG_STATUS) |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_flag_pad: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ18]
      regRd && regAddr == REG_RFLG |=> (regRdata & ~RFLG_MASK) == 8'h00)
      else $error("reserved flag bit set");
   a_lowv_set: assert property (@(posedge ref_clk) disable iff (por_rst) // [RQ4]
      ev_s2_r[3] |=> rflg_r[LOWV_BIT]) else $error("flag lost");
   a_oscloss_set: assert property (@(posedge ref_clk) disable iff (por_rst) // [RQ5]
      ev_s2_r[1] |=> rflg_r[OSCLOSS_BIT]) else $error("flag lost");
   a_pllloss_set: assert property (@(posedge ref_clk) disable iff (por_rst) // [RQ5]
      ev_s2_r[0] |=> rflg_r[PLLLOSS_BIT]) else $error("flag lost");
   a_pwron_keep: assert property (@(posedge ref_clk) disable iff (por_rst) // [RQ3]
      !(regWr && regAddr == REG_RFLG && regWdata[PWRON_BIT])
      |=> rflg_r[PWRON_BIT] == $past(rflg_r[PWRON_BIT])) else $error("flag moved");
   a_trim0_fetch: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ2]
      tl_r == TL_FETCH && flashAck && !flashSel_r
      |=> trim0_r == ($past(flashData) & TRIM0_MASK)) else $error("trim load");
   a_trim1_fetch: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ2]
      tl_r == TL_FETCH && flashAck && flashSel_r
      |=> trim1_r == ($past(flashData) & TRIM1_MASK)) else $error("trim load");
   a_filter_ext: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ14]
      osc_enable |-> filter_range == ref_div_r[7:6])
      else $error("filter not from field");
   a_status_follow: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ8]
      !anyClr |=> pll_settled == $past(lock_s2_r))
      else $error("status not following");
   a_ramp_step: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ17]
      1'b1 |=> pllDivider == $past(pllDivider)
      || pllDivider == $past(pllDivider) + 5'h01
      || pllDivider == $past(pllDivider) - 5'h01) else $error("ramp jumped");
   a_clear_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ9]
      statusClear |-> regWr) else $error("stray status clear");
   c_synth_wr: cover property (@(posedge ref_clk) wrSynth);
   c_trim_load: cover property (@(posedge ref_clk) tl_r == TL_DONE);
   c_flag_clr: cover property (@(posedge ref_clk)
      regWr && regAddr == REG_RFLG && regWdata[WDRF_BIT]);
   c_ramp: cover property (@(posedge ref_clk) wrPost ##[1:32] rif.settled);
   c_lock_ramp: cover property (@(posedge ref_clk)
      lock_sync_r && !lock_prev_r);
endmodule

// ===== test/pcrf_top_tb.sv
`timescale 1ns/10ps
module pcrf_top_tb;
   import pcrf_pkg::*;
   logic ref_clk = 0, sys_rst = 1, por_rst = 1, regWr = 0, regRd = 0;
   logic [3:0] regAddr = 4'h0, ev = 4'h0;
   logic [7:0] regWdata = 8'h00, flashData = 8'h00, regRdata;
   logic special_mode = 0, pll_select = 0, write_protect = 0;
   logic osc_enable = 0, lock_raw = 0, osc_ok_raw = 0, flashAck = 0;
   logic flashReq, flashSel, pll_settled, osc_qualified, statusClear;
   logic use_internal_ref, clr, ok;
   logic [5:0] multiplier_field;
   logic [1:0] vco_range_field, filter_range;
   logic [3:0] reference_divider_field;
   logic [4:0] pllDivider;
   logic [7:0] rd, d, flg, syn, rdv, pdv, msk;
   logic [7:0] trimExp[2];
   int failures = 0, checks_done = 0, n;
   int fb[4] = '{LOWV_BIT, WDRF_BIT, OSCLOSS_BIT, PLLLOSS_BIT};

   pcrf_top u_pcrf_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .por_rst(por_rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .special_mode(special_mode), .pll_select(pll_select),
      .write_protect(write_protect), .osc_enable(osc_enable),
      .lock_raw(lock_raw), .osc_ok_raw(osc_ok_raw), .lvr_event(ev[0]),
      .wdog_event(ev[1]), .osc_loss_event(ev[2]), .pll_loss_event(ev[3]),
      .flashReq(flashReq), .flashSel(flashSel), .flashAck(flashAck),
      .flashData(flashData), .multiplier_field(multiplier_field),
      .vco_range_field(vco_range_field),
      .reference_divider_field(reference_divider_field),
      .filter_range(filter_range), .use_internal_ref(use_internal_ref),
      .pllDivider(pllDivider), .pll_settled(pll_settled),
      .osc_qualified(osc_qualified), .statusClear(statusClear));

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   // flash answers every request one cycle later with fresh data
   always @(posedge ref_clk) begin
      if (flashAck === 1'b1) trimExp[flashSel] = flashData;
      flashAck <= flashReq && !flashAck;
      flashData <= 8'($urandom);
   end

   task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      #1 clr = statusClear;
      @(posedge ref_clk);
      regWr <= 1'b0;
      #1;
   endtask

   task rdr(input logic [3:0] a);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 rd = regRdata;
   endtask

   // por also pulses system reset, as on the chip
   task rst(input logic por);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      por_rst <= por;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      por_rst <= 1'b0;
      syn = 8'h00;
      rdv = 8'h00;
      pdv = 8'h00;
      if (por) flg = 8'h60;
      repeat (3) @(posedge ref_clk);
      n = 0;
      #1;
      while (flashReq !== 1'b0 && n < 50) begin
         @(posedge ref_clk);
         n++;
      end
      chk(8'(n < 50), 8'h01, "trim load hang");
   endtask

   task summarize;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #(40 * 6000);
      failures++;
      summarize;
   end

   initial begin
      void'($urandom(51649));
      rst(1'b1);
      rdr(REG_RFLG);
      chk(rd, flg, "por flags");
      chk({3'h0, pllDivider}, {3'h0, UNLOCK_DIV}, "unlock div");
      $display("test reset done");
      for (int i = 0; i < 2; i++) begin
         msk = i ? TRIM1_MASK : TRIM0_MASK;
         rdr(REG_TRIM0 + 4'(i));
         chk(rd, trimExp[i] & msk, "trim load");
         wr(REG_TRIM0 + 4'(i), 8'($urandom));
         rdr(REG_TRIM0 + 4'(i));
         chk(rd, trimExp[i] & msk, "trim normal write");
         @(posedge ref_clk) special_mode <= 1'b1;
         d = 8'($urandom);
         wr(REG_TRIM0 + 4'(i), d);
         rdr(REG_TRIM0 + 4'(i));
         chk(rd, d & msk, "trim special write");
         @(posedge ref_clk) special_mode <= 1'b0;
      end
      $display("test trim done");
      wr(REG_RFLG, 8'h00);
      rdr(REG_RFLG);
      chk(rd, flg, "flag zero write");
      wr(REG_RFLG, 8'hFF);
      flg = 8'h00;
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk) ev[i] <= 1'b1;
         repeat (2) @(posedge ref_clk);
         ev[i] <= 1'b0;
         repeat (5) @(posedge ref_clk);
         flg[fb[i]] = 1'b1;
         rdr(REG_RFLG);
         chk(rd, flg, "event flag");
      end
      wr(REG_RFLG, 8'h08);
      flg[WDRF_BIT] = 1'b0;
      rst(1'b0);
      rdr(REG_RFLG);
      chk(rd, flg, "flags kept over sys reset");
      $display("test flags done");
      for (int k = 0; k < 4; k++) begin
         @(posedge ref_clk) begin
            write_protect <= k[0];
            pll_select <= k[1];
            lock_raw <= 1'b1;
            osc_ok_raw <= 1'b1;
            osc_enable <= k[1] ^ k[0];
         end
         ok = (k == 2);
         repeat (6) @(posedge ref_clk);
         d = {2'(k), 6'($urandom)};
         wr(REG_SYNR, d);
         chk({7'h00, clr}, {7'h00, ok}, "syn clear pulse");
         chk({6'h00, pll_settled, osc_qualified}, ok ? 8'h00 : 8'h03,
             "syn status");
         if (ok) syn = d;
         chk({2'h0, multiplier_field}, {2'h0, syn[5:0]}, "mult");
         chk({6'h0, vco_range_field}, {6'h0, syn[7:6]}, "vco");
         repeat (6) @(posedge ref_clk);
         d = 8'($urandom);
         wr(REG_REF_DIV, d);
         chk({7'h00, clr}, {7'h00, ok}, "ref clear pulse");
         chk({6'h00, pll_settled, osc_qualified}, ok ? 8'h00 : 8'h03,
             "ref status");
         if (ok) rdv = d & REF_DIV_MASK;
         rdr(REG_REF_DIV);
         chk(rd, rdv, "ref divider read");
         chk({4'h0, reference_divider_field}, {4'h0, rdv[3:0]}, "rdiv");
         chk({6'h0, filter_range}, {6'h0, osc_enable ? rdv[7:6] : FILTER_1M},
             "filter");
         chk({7'h0, use_internal_ref}, {7'h0, !osc_enable}, "int ref");
      end
      $display("test pll config done");
      for (int k = 0; k < 5; k++) begin
         @(posedge ref_clk) pll_select <= (k != 1);
         lock_raw <= (k != 4);
         d = (k == 0) ? 8'hFF : (k == 3) ? 8'hE0 : 8'($urandom);
         wr(REG_OUT_DIV, d);
         if (k != 1) pdv = d & OUT_DIV_MASK;
         rdr(REG_OUT_DIV);
         chk(rd, pdv, "out divider read");
         msk = (k == 4) ? {3'h0, UNLOCK_DIV} : pdv;
         n = 0;
         while (pllDivider !== msk[4:0] && n < 40) begin
            @(posedge ref_clk);
            n++;
         end
         chk(8'(n <= 32), 8'h01, "ramp time");
         chk({3'h0, pllDivider}, msk, "ramp target");
      end
      $display("test ramp done");
      rdr(4'hF);
      chk(rd, 8'h00, "unmapped");
      rdr(4'h0);
      chk(rd, 8'h00, "reserved");
      rst(1'b1);
      rdr(REG_RFLG);
      chk(rd, flg, "por clears flags");
      $display("test por done");
      summarize;
   end
endmodule
